// ### design/urma_pkg.sv
package urma_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] OFS_HOLD = 4'h0;
   localparam logic [3:0] OFS_IRQEN = 4'h1;
   localparam logic [3:0] OFS_FIFOCTL = 4'h2;
   localparam logic [3:0] OFS_LINE = 4'h3;
   localparam logic [3:0] OFS_MODEM = 4'h4;
   localparam logic [3:0] OFS_LSTAT = 4'h5;
   localparam logic [3:0] OFS_MSTAT = 4'h6;
   localparam logic [3:0] OFS_SCRATCH = 4'h7;
   localparam logic [3:0] OFS_TXLEVEL = 4'h8;
   localparam logic [3:0] OFS_RXLEVEL = 4'h9;
   localparam logic [3:0] OFS_IO_PIN_DIRECTION = 4'ha;
   localparam logic [3:0] OFS_IOLVL = 4'hb;
   localparam logic [3:0] OFS_IOIRQ = 4'hc;
   localparam logic [3:0] OFS_RSVD = 4'hd;
   localparam logic [3:0] OFS_IOCTL = 4'he;
   localparam logic [3:0] OFS_XFEAT = 4'hf;
   localparam logic [3:0] OFS_DIVLO = 4'h0;
   localparam logic [3:0] OFS_DIVHI = 4'h1;
   localparam logic [3:0] OFS_ENHF = 4'h2;
   localparam logic [3:0] OFS_RES1 = 4'h4;
   localparam logic [3:0] OFS_RES2 = 4'h5;
   localparam logic [3:0] OFS_PAU1 = 4'h6;
   localparam logic [3:0] OFS_PAU2 = 4'h7;

   // ---------------------------------------------------------------
   // Field positions and special values
   // ---------------------------------------------------------------
   localparam int LINE_DIV_BIT = 7;
   localparam logic [7:0] LINE_ENH_KEY = 8'hbf;
   localparam int ENH_EN_BIT = 4;
   localparam int MODEM_THR_EN_BIT = 2;
   localparam int FIFO_EN_BIT = 0;
   localparam int FIFO_RXRST_BIT = 1;
   localparam int FIFO_TXRST_BIT = 2;
   localparam int IOCTL_SWRST_BIT = 3;
   localparam int LINE_WLEN_HI = 1;
   localparam int LINE_WLEN_LO = 0;
   localparam int XFEAT_RXOFF_BIT = 1;
   localparam logic [7:0] IOCTL_SWRST_MASK = 8'h08;
   // Bits that only change while enhanced functions are enabled
   localparam logic [7:0] IRQEN_ENH_MASK = 8'hf0;
   localparam logic [7:0] FIFOCTL_ENH_MASK = 8'h30;
   localparam logic [7:0] MODEM_ENH_MASK = 8'he4;
   // Writable bit masks, reserved positions held at zero
   localparam logic [7:0] MODEM_WR_MASK = 8'hf7;
   localparam logic [7:0] IOCTL_WR_MASK = 8'h0b;
   localparam logic [7:0] XFEAT_WR_MASK = 8'hb7;
   localparam logic [7:0] FIFOCTL_WR_MASK = 8'hf1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ---------------------------------------------------------------
   // FIFO and receiver timing
   // ---------------------------------------------------------------
   localparam int FIFO_DEPTH = 64;
   localparam int FIFO_AW = 6;
   localparam int CLK_PERIOD_NS = 25;
   localparam int FIFO_RST_CLKS = 2;
   localparam int SAMPLES_PER_BIT = 16;
   // Mid-point of the start bit and last sample of a bit, 16 samples per bit
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [3:0] TICK_LAST = 4'hf;
   localparam logic [6:0] FIFO_DEPTH_W = 7'h40;

   // Host access port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } urma_req_t;

   typedef enum logic [1:0] {URMA_RX_IDLE, URMA_RX_START, URMA_RX_DATA, URMA_RX_STOP}
      urma_rx_state_t;

endpackage : urma_pkg

// ### design/urma_regs.sv
`timescale 1ns/100ps
// How it works
// RULE1: General set decodes only while line-format bit 7 is zero; the code also decodes offsets 8 to 0x0f in the divisor set.
// RULE2: Divisor bytes at 0 and 1 when bit 7 set and line-format not 0xbf.
// RULE3: Enhanced set (feature control, four flow chars) only at line-format 0xbf.
// RULE4: Flow and trigger thresholds at 6 and 7 need modem bit 2 and enhanced enable.
// RULE5: Writes to enhanced-function bits ignored unless enhanced enable set.
// RULE6: Host writes zero to reserved bits and the reserved slot.
// RULE7: Host waits two clocks after FIFO reset before data access.
// RULE8: Host does not burst-read interrupt identity.
// RULE9: Receive holding store is a 64-byte first-in first-out.
// RULE10: Serial receive bits shift in, complete characters move into the FIFO.
// RULE11: Receiver character format comes from line-format control.
// RULE12: With FIFOs disabled, characters still land in entry zero only.
// RULE13: Enhanced feature control at 2: cts, rts, special, enable, flow mode.
// RULE14: Extra feature control at 0x0f: ir speed, rs485 bits, disables, 9-bit.
// RULE15: I/O control at 0x0e: software reset, pin function, input latch.
// RULE16: Reserved slot reads zero, writes dropped.
module urma_regs
   import urma_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire urma_req_t req,
   output logic [7:0] rdata,
   input wire logic rx_pin,
   output logic [7:0] line_format_control,
   output logic [7:0] modem_line_control,
   output logic [7:0] enhanced_feature_control,
   output logic [7:0] extra_feature_control,
   output logic [7:0] io_pin_control,
   output logic [15:0] divisor
);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   logic [7:0] irqen_r, fifoctl_r, scratch_r, divlo_r, divhi_r;
   logic [7:0] res1_r, res2_r, pau1_r, pau2_r, thr_r, tlr_r;
   logic [7:0] io_pin_direction_r, iolvl_r, ioirq_r;
   logic [7:0] lcr_r, mcr_r, efr_r, extra_feature_control_r, ioctl_r;
   logic [7:0] fifo_mem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wptr_r, rptr_r;
   logic [6:0] count_r;
   logic [7:0] rdata_r;

   // ---------------------------------------------------------------
   // Set selection
   // ---------------------------------------------------------------
   wire enh_set = (lcr_r == LINE_ENH_KEY); // [RULE3]
   wire div_set = lcr_r[LINE_DIV_BIT] && !enh_set; // [RULE2]
   wire gen_set = !lcr_r[LINE_DIV_BIT]; // [RULE1]
   wire enh_on = efr_r[ENH_EN_BIT];
   wire thr_set = gen_set && mcr_r[MODEM_THR_EN_BIT] && enh_on; // [RULE4]
   // Upper general offsets stay reachable in the divisor set too
   wire upper = req.addr >= OFS_TXLEVEL;
   wire any_gen = gen_set || (div_set && upper);

   // Write strobes; line format stays writable from every set
   wire wr_lcr_any = req.wr && (req.addr == OFS_LINE);
   wire wr_divlo = req.wr && div_set && (req.addr == OFS_DIVLO);
   wire wr_divhi = req.wr && div_set && (req.addr == OFS_DIVHI);
   wire wr_efr = req.wr && enh_set && (req.addr == OFS_ENHF);
   wire wr_res1 = req.wr && enh_set && (req.addr == OFS_RES1);
   wire wr_res2 = req.wr && enh_set && (req.addr == OFS_RES2);
   wire wr_pau1 = req.wr && enh_set && (req.addr == OFS_PAU1);
   wire wr_pau2 = req.wr && enh_set && (req.addr == OFS_PAU2);
   wire wr_irqen = req.wr && gen_set && (req.addr == OFS_IRQEN);
   wire wr_fifo = req.wr && gen_set && (req.addr == OFS_FIFOCTL);
   wire wr_mcr = req.wr && gen_set && (req.addr == OFS_MODEM);
   wire wr_msr6 = req.wr && thr_set && (req.addr == OFS_MSTAT);
   wire wr_spr = req.wr && gen_set && (req.addr == OFS_SCRATCH);
   wire wr_spr7 = wr_spr && thr_set;
   wire wr_io_pin_direction = req.wr && any_gen && (req.addr == OFS_IO_PIN_DIRECTION);
   wire wr_iolvl = req.wr && any_gen && (req.addr == OFS_IOLVL);
   wire wr_ioirq = req.wr && any_gen && (req.addr == OFS_IOIRQ);
   wire wr_ioctl = req.wr && any_gen && (req.addr == OFS_IOCTL);
   wire wr_extra_feature_control = req.wr && any_gen && (req.addr == OFS_XFEAT);
   wire rd_rhr = req.rd && gen_set && (req.addr == OFS_HOLD);

   // Enhanced-only bits keep their value while the enable is clear
   wire [7:0] irq_keep = enh_on ? 8'h00 : IRQEN_ENH_MASK; // [RULE5]
   wire [7:0] fcr_keep = enh_on ? 8'h00 : FIFOCTL_ENH_MASK; // [RULE5]
   wire [7:0] mcr_keep = enh_on ? 8'h00 : MODEM_ENH_MASK; // [RULE5]
   wire [7:0] irqen_nxt = (irqen_r & irq_keep) | (req.wdata & ~irq_keep);
   wire [7:0] fifoctl_nxt = ((fifoctl_r & fcr_keep) | (req.wdata & ~fcr_keep))
                            & FIFOCTL_WR_MASK;
   wire [7:0] mcr_nxt = ((mcr_r & mcr_keep) | (req.wdata & ~mcr_keep)) & MODEM_WR_MASK;
   wire soft_rst = wr_ioctl && req.wdata[IOCTL_SWRST_BIT]; // [RULE15]
   wire rx_flush = soft_rst || (wr_fifo && req.wdata[FIFO_RXRST_BIT]);
   wire fifo_on = fifoctl_r[FIFO_EN_BIT];

   // ---------------------------------------------------------------
   // Control register writes
   // ---------------------------------------------------------------
   // Control registers; software reset clears them like a hard reset
   always_ff @(posedge sys_clk) begin
      if (reset || soft_rst) begin
         lcr_r <= BYTE_ZERO;
         mcr_r <= BYTE_ZERO;
         efr_r <= BYTE_ZERO;
         irqen_r <= BYTE_ZERO;
         fifoctl_r <= BYTE_ZERO;
         extra_feature_control_r <= BYTE_ZERO;
      end else begin
         if (wr_lcr_any) lcr_r <= req.wdata;
         if (wr_efr) efr_r <= req.wdata; // [RULE13]
         if (wr_irqen) irqen_r <= irqen_nxt;
         if (wr_fifo) fifoctl_r <= fifoctl_nxt;
         if (wr_mcr) mcr_r <= mcr_nxt;
         if (wr_extra_feature_control) extra_feature_control_r <= req.wdata & XFEAT_WR_MASK; // [RULE14]
      end
   end

   // Data registers; software reset leaves them alone
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         {divlo_r, divhi_r, res1_r, res2_r, pau1_r, pau2_r} <= '0;
         {scratch_r, thr_r, tlr_r, io_pin_direction_r, iolvl_r, ioirq_r, ioctl_r} <= '0;
      end else begin
         if (wr_divlo) divlo_r <= req.wdata;
         if (wr_divhi) divhi_r <= req.wdata;
         if (wr_res1) res1_r <= req.wdata;
         if (wr_res2) res2_r <= req.wdata;
         if (wr_pau1) pau1_r <= req.wdata;
         if (wr_pau2) pau2_r <= req.wdata;
         if (wr_msr6) thr_r <= req.wdata; // [RULE4]
         if (wr_spr7) tlr_r <= req.wdata; // [RULE4]
         else if (wr_spr && !thr_set) scratch_r <= req.wdata;
         if (wr_io_pin_direction) io_pin_direction_r <= req.wdata;
         if (wr_iolvl) iolvl_r <= req.wdata;
         if (wr_ioirq) ioirq_r <= req.wdata;
         // Reset bit self-clears, so it never reads back as one
         if (wr_ioctl) ioctl_r <= req.wdata & IOCTL_WR_MASK & ~IOCTL_SWRST_MASK; // [RULE15]
      end
   end

   // ---------------------------------------------------------------
   // Receiver: synchroniser, 16x oversampling shift stage
   // ---------------------------------------------------------------
   logic rx_s1_r, rx_s2_r;
   urma_rx_state_t rx_st_r;
   logic [3:0] tick_r;
   logic [15:0] baud_r;
   logic [2:0] bit_r;
   logic [7:0] shift_r;
   logic char_done;
   // Word length picks the last data bit; receive can be switched off
   wire baud_tick = (baud_r == 16'h0000);
   wire [2:0] last_bit = {1'b1, lcr_r[LINE_WLEN_HI:LINE_WLEN_LO]}; // [RULE11]
   wire rx_enabled = !extra_feature_control_r[XFEAT_RXOFF_BIT];

   // Two flops; the pin is asynchronous and idles high
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= rx_pin;
         rx_s2_r <= rx_s1_r;
      end
   end

   // Baud prescaler from the divisor latch (zero means every clock)
   // A divisor write restarts the count, so a new rate never waits out an old one
   always_ff @(posedge sys_clk) begin
      if (reset || wr_divlo || wr_divhi) baud_r <= '0;
      else if (baud_tick) baud_r <= {divhi_r, divlo_r};
      else baud_r <= baud_r - 16'h0001;
   end

   // Character assembly; no parity bit is taken and the stop bit is timed but not sampled or checked
   always_ff @(posedge sys_clk) begin
      if (reset || soft_rst) begin
         rx_st_r <= URMA_RX_IDLE;
         tick_r <= 4'h0;
         bit_r <= 3'h0;
         shift_r <= BYTE_ZERO;
      end else if (baud_tick) begin
         tick_r <= tick_r + 4'h1;
         case (rx_st_r)
            URMA_RX_IDLE: begin
               tick_r <= 4'h0;
               if (!rx_s2_r && rx_enabled) rx_st_r <= URMA_RX_START;
            end
            URMA_RX_START: begin
               if (tick_r == TICK_MID) begin
                  tick_r <= 4'h0;
                  bit_r <= 3'h0;
                  shift_r <= BYTE_ZERO;
                  rx_st_r <= rx_s2_r ? URMA_RX_IDLE : URMA_RX_DATA;
               end
            end
            URMA_RX_DATA: begin
               if (tick_r == TICK_LAST) begin
                  shift_r[bit_r] <= rx_s2_r; // [RULE10]
                  bit_r <= bit_r + 3'h1;
                  if (bit_r == last_bit) rx_st_r <= URMA_RX_STOP;
               end
            end
            URMA_RX_STOP: begin
               if (tick_r == TICK_LAST) rx_st_r <= URMA_RX_IDLE;
            end
            default: rx_st_r <= URMA_RX_IDLE;
         endcase
      end
   end
   assign char_done = baud_tick && (rx_st_r == URMA_RX_STOP) && (tick_r == TICK_LAST);

   // ---------------------------------------------------------------
   // Receive holding FIFO
   // ---------------------------------------------------------------
   // With the FIFO off one stored character already counts as full
   wire fifo_empty = (count_r == 7'h00);
   wire fifo_full = fifo_on ? (count_r == FIFO_DEPTH_W) : !fifo_empty;
   wire push = char_done && !fifo_full; // [RULE10]
   wire pop = rd_rhr && !fifo_empty;
   wire [FIFO_AW-1:0] wr_idx = fifo_on ? wptr_r : '0; // [RULE12]
   wire [FIFO_AW-1:0] rd_idx = fifo_on ? rptr_r : '0; // [RULE12]

   // Storage has no reset; the count alone says what is valid
   always_ff @(posedge sys_clk) begin
      if (push) fifo_mem[wr_idx] <= shift_r; // [RULE9]
   end

   // Pointers wrap at the depth; overflow drops the new character
   always_ff @(posedge sys_clk) begin
      if (reset || rx_flush) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= 7'h00;
      end else begin
         if (push && fifo_on) wptr_r <= wptr_r + 6'h01;
         if (pop && fifo_on) rptr_r <= rptr_r + 6'h01;
         count_r <= count_r + {6'h00, push} - {6'h00, pop}; // [RULE9]
      end
   end

   // ---------------------------------------------------------------
   // Read decode, one cycle registered
   // ---------------------------------------------------------------
   // Address decode; unmapped offsets read zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = BYTE_ZERO;
      if (enh_set && req.addr == OFS_LINE) rd_mux = lcr_r;
      else if (enh_set && req.addr == OFS_ENHF) rd_mux = efr_r; // [RULE3]
      else if (enh_set && req.addr == OFS_RES1) rd_mux = res1_r;
      else if (enh_set && req.addr == OFS_RES2) rd_mux = res2_r;
      else if (enh_set && req.addr == OFS_PAU1) rd_mux = pau1_r;
      else if (enh_set && req.addr == OFS_PAU2) rd_mux = pau2_r;
      else if (div_set && req.addr == OFS_DIVLO) rd_mux = divlo_r; // [RULE2]
      else if (div_set && req.addr == OFS_DIVHI) rd_mux = divhi_r;
      else if (!any_gen && !(div_set && req.addr == OFS_LINE)) rd_mux = BYTE_ZERO;
      else if (req.addr == OFS_HOLD) rd_mux = fifo_empty ? BYTE_ZERO : fifo_mem[rd_idx];
      else if (req.addr == OFS_IRQEN) rd_mux = irqen_r; // [RULE1]
      else if (req.addr == OFS_LINE) rd_mux = lcr_r;
      else if (req.addr == OFS_MODEM) rd_mux = mcr_r;
      else if (req.addr == OFS_LSTAT) rd_mux = {7'h00, !fifo_empty};
      else if (req.addr == OFS_MSTAT) rd_mux = thr_set ? thr_r : BYTE_ZERO;
      else if (req.addr == OFS_SCRATCH) rd_mux = thr_set ? tlr_r : scratch_r;
      else if (req.addr == OFS_TXLEVEL) rd_mux = {1'b0, FIFO_DEPTH_W};
      else if (req.addr == OFS_RXLEVEL) rd_mux = {1'b0, count_r};
      else if (req.addr == OFS_IO_PIN_DIRECTION) rd_mux = io_pin_direction_r;
      else if (req.addr == OFS_IOLVL) rd_mux = iolvl_r;
      else if (req.addr == OFS_IOIRQ) rd_mux = ioirq_r;
      else if (req.addr == OFS_RSVD) rd_mux = BYTE_ZERO; // [RULE16]
      else if (req.addr == OFS_IOCTL) rd_mux = ioctl_r;
      else if (req.addr == OFS_XFEAT) rd_mux = extra_feature_control_r;
   end

   // Read data holds until the next read strobe
   always_ff @(posedge sys_clk) begin
      if (reset) rdata_r <= BYTE_ZERO;
      else if (req.rd) rdata_r <= rd_mux;
   end

   // Outputs straight from flops
   assign rdata = rdata_r;
   assign line_format_control = lcr_r;
   assign modem_line_control = mcr_r;
   assign enhanced_feature_control = efr_r;
   assign extra_feature_control = extra_feature_control_r;
   assign io_pin_control = ioctl_r;
   assign divisor = {divhi_r, divlo_r};

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_div_write_gated: assert property (wr_divlo |=> divlo_r == $past(req.wdata)) // [RULE2]
      else $error("divisor low not written");
   a_div_hidden_enh: assert property (enh_set && req.wr && req.addr == OFS_DIVLO
      |=> $stable(divlo_r)) else $error("divisor written in enhanced set"); // [RULE2]
   a_enh_key_only: assert property (!enh_set && req.wr && req.addr == OFS_ENHF
      && !soft_rst |=> $stable(efr_r)) else $error("feature reg written off key"); // [RULE3]
   a_gen_hidden_div: assert property (lcr_r[LINE_DIV_BIT] && req.wr && req.addr == OFS_MODEM
      && !soft_rst |=> $stable(mcr_r)) else $error("modem written in divisor set"); // [RULE1]
   a_thr_gate: assert property (!thr_set && req.wr && req.addr == OFS_MSTAT
      |=> $stable(thr_r)) else $error("threshold written while gated"); // [RULE4]
   a_enh_bits_lock: assert property (!enh_on && wr_irqen && !soft_rst
      |=> irqen_r[7:4] == $past(irqen_r[7:4])) else $error("enhanced bits changed"); // [RULE5]
   a_rsvd_zero: assert property (req.rd && any_gen && req.addr == OFS_RSVD
      |=> rdata == 8'h00) else $error("reserved slot not zero"); // [RULE16]
   a_fifo_bound: assert property (count_r <= FIFO_DEPTH_W) // [RULE9]
      else $error("fifo count overflow");
   a_single_entry: assert property (!fifo_on && !rx_flush |=> count_r <= 7'h01) // [RULE12]
      else $error("more than one entry with fifo off");
   a_char_push: assert property (char_done && fifo_empty && !rx_flush && !pop
      |=> !fifo_empty) else $error("character lost"); // [RULE10]
   a_soft_clear: assert property (soft_rst |=> lcr_r == BYTE_ZERO // [RULE15]
      && extra_feature_control_r == BYTE_ZERO && count_r == 7'h00)
      else $error("software reset left state behind");
   a_swrst_clear: assert property (wr_ioctl // [RULE15]
      |=> !ioctl_r[IOCTL_SWRST_BIT])
      else $error("software reset bit reads back set");
   a_enh_read: assert property (req.rd && enh_set && req.addr == OFS_ENHF // [RULE3]
      |=> rdata == $past(efr_r))
      else $error("feature control read back wrong");
   a_div_read: assert property (req.rd && div_set && req.addr == OFS_DIVHI // [RULE2]
      |=> rdata == $past(divhi_r))
      else $error("divisor high read back wrong");
   a_level_read: assert property (req.rd && any_gen && req.addr == OFS_RXLEVEL // [RULE9]
      |=> rdata == {1'b0, $past(count_r)})
      else $error("fill level read back wrong");
   a_xfeat_mask: assert property (wr_extra_feature_control // [RULE14]
      |=> (extra_feature_control_r & ~XFEAT_WR_MASK) == BYTE_ZERO)
      else $error("reserved extra feature bit set");

   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------

   c_char_rx: cover property (push);
   c_enh_write: cover property (wr_efr);
   c_full: cover property (count_r == FIFO_DEPTH_W);
   c_div_read: cover property (req.rd && div_set);
   c_soft_rst: cover property (soft_rst);

endmodule : urma_regs

// ### verif/uart_register_map_access_tb.sv
`timescale 1ns/100ps
module uart_register_map_access_tb;
   import urma_pkg::*;
   logic sys_clk;
   logic reset;
   urma_req_t req;
   logic [7:0] rdata;
   logic rx_pin;
   logic [7:0] line_format_control;
   logic [7:0] modem_line_control;
   logic [7:0] enhanced_feature_control;
   logic [7:0] extra_feature_control;
   logic [7:0] io_pin_control;
   logic [15:0] divisor;
   logic [7:0] exp_q[$];
   logic [7:0] sent[$];
   logic rd_pend = 1'b0;
   int err_total = 0;
   int num_checks = 0;
   int seed = 32'hce515cd4;

   urma_regs urma_regs_i (.sys_clk(sys_clk), .reset(reset), .req(req), .rdata(rdata),
      .rx_pin(rx_pin), .line_format_control(line_format_control),
      .modem_line_control(modem_line_control),
      .enhanced_feature_control(enhanced_feature_control),
      .extra_feature_control(extra_feature_control), .io_pin_control(io_pin_control),
      .divisor(divisor));
   urma_line_src #(.BIT_CLKS(SAMPLES_PER_BIT)) urma_line_src_i (.sys_clk(sys_clk),
      .rx_line(rx_pin));

   // ---------------------------------------------------------------
   // Clock, report and bus tasks
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   task automatic fail(input string msg);
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
   endtask : fail

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         fail(msg);
      end
   endtask : chk

   // Strobes are held only one cycle; callers idle before any wait
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      exp_q.push_back(e);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) begin
         @(negedge sys_clk);
         req = '0;
      end
   endtask : idle

   // Read data lands one edge after the strobe; oldest note is compared
   always @(posedge sys_clk) rd_pend <= req.rd & ~reset;
   always @(negedge sys_clk) begin
      if (rd_pend) begin
         if (exp_q.size() == 0) begin
            fail("read answer without expectation");
         end else begin
            chk({8'h00, rdata}, {8'h00, exp_q.pop_front()}, "read data");
         end
      end
   end

   // Hang guard: cuts the run short and reports
   initial begin
      repeat (100000) @(posedge sys_clk);
      fail("run timed out");
      test_done();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] b;
      req = '0;
      reset = 1'b1;
      repeat (6) @(negedge sys_clk);
      reset = 1'b0;
      chk({line_format_control, modem_line_control}, 16'h0000, "reset value");
      chk({enhanced_feature_control, extra_feature_control}, 16'h0000, "reset value");
      chk({io_pin_control, 8'h00}, 16'h0000, "reset value");
      chk(divisor, 16'h0000, "reset divisor");
      rd(OFS_TXLEVEL, 8'(FIFO_DEPTH_W));
      rd(OFS_RXLEVEL, BYTE_ZERO);
      wr(OFS_RSVD, 8'h00);
      rd(OFS_RSVD, BYTE_ZERO);
      // Divisor set and upper control registers, back to back
      wr(OFS_LINE, 8'h80);
      wr(OFS_DIVLO, 8'h12);
      wr(OFS_DIVHI, 8'h34);
      rd(OFS_DIVLO, 8'h12);
      rd(OFS_DIVHI, 8'h34);
      rd(OFS_LINE, 8'h80);
      wr(OFS_MODEM, 8'h01);
      wr(OFS_XFEAT, XFEAT_WR_MASK);
      rd(OFS_XFEAT, XFEAT_WR_MASK);
      wr(OFS_IOCTL, 8'h03);
      rd(OFS_IOCTL, 8'h03);
      // Enhanced set: divisor slots must not answer here
      wr(OFS_LINE, LINE_ENH_KEY);
      wr(OFS_DIVLO, 8'h99);
      wr(OFS_ENHF, 8'hd5);
      for (int i = 4; i < 8; i++) begin
         wr(4'(i), 8'(8'h11 * i));
      end
      for (int i = 4; i < 8; i++) begin
         rd(4'(i), 8'(8'h11 * i));
      end
      rd(OFS_ENHF, 8'hd5);
      rd(OFS_LINE, LINE_ENH_KEY);
      idle(1);
      chk(divisor, 16'h3412, "divisor hit from enhanced set");
      chk({enhanced_feature_control, modem_line_control}, 16'hd500, "feature control");
      chk({extra_feature_control, 8'h00}, 16'hb700, "extra feature");
      // General set with enhanced functions enabled
      wr(OFS_LINE, 8'h00);
      wr(OFS_IRQEN, 8'hff);
      rd(OFS_IRQEN, 8'hff);
      wr(OFS_MODEM, MODEM_WR_MASK);
      rd(OFS_MODEM, MODEM_WR_MASK);
      wr(OFS_MSTAT, 8'h5a);
      wr(OFS_SCRATCH, 8'h77);
      rd(OFS_MSTAT, 8'h5a);
      rd(OFS_SCRATCH, 8'h77);
      wr(OFS_MODEM, 8'h00);
      wr(OFS_MSTAT, 8'h33);
      wr(OFS_SCRATCH, 8'h11);
      rd(OFS_SCRATCH, 8'h11);
      wr(OFS_MODEM, 8'h04);
      rd(OFS_SCRATCH, 8'h77);
      rd(OFS_MSTAT, 8'h5a);
      // Enhanced enable off: enhanced bits hold their old values
      wr(OFS_LINE, LINE_ENH_KEY);
      wr(OFS_ENHF, 8'h00);
      wr(OFS_LINE, 8'h00);
      wr(OFS_IRQEN, 8'h00);
      rd(OFS_IRQEN, 8'hf0);
      wr(OFS_MODEM, MODEM_WR_MASK);
      rd(OFS_SCRATCH, 8'h11);
      idle(1);
      chk({modem_line_control, 8'h00}, 16'h1700, "modem enhanced bits");
      chk(divisor, 16'h3412, "divisor hit from general set");
      // Software reset clears the control registers
      wr(OFS_IOCTL, 8'h08);
      idle(1);
      chk({line_format_control, modem_line_control}, 16'h0000, "soft reset");
      chk({enhanced_feature_control, extra_feature_control}, 16'h0000, "soft reset");
      chk({15'h0000, io_pin_control[IOCTL_SWRST_BIT]}, 16'h0000, "reset bit");
      // Fill the receive store past its depth, then drain it
      wr(OFS_LINE, 8'h80);
      wr(OFS_DIVLO, BYTE_ZERO);
      wr(OFS_DIVHI, BYTE_ZERO);
      wr(OFS_LINE, 8'h03);
      wr(OFS_FIFOCTL, 8'h03);
      idle(FIFO_RST_CLKS);
      for (int i = 0; i <= FIFO_DEPTH; i++) begin
         b = 8'($random(seed));
         sent.push_back(b);
         urma_line_src_i.send(b, 8);
      end
      idle(4);
      rd(OFS_RXLEVEL, 8'(FIFO_DEPTH_W));
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         rd(OFS_HOLD, sent[i]);
      end
      rd(OFS_RXLEVEL, BYTE_ZERO);
      // Five-bit characters with the FIFO switched off
      wr(OFS_LINE, 8'h00);
      wr(OFS_FIFOCTL, 8'h00);
      idle(FIFO_RST_CLKS);
      urma_line_src_i.send(8'hff, 5);
      urma_line_src_i.send(8'h0a, 5);
      idle(4);
      rd(OFS_RXLEVEL, 8'h01);
      rd(OFS_HOLD, 8'h1f);
      rd(OFS_RXLEVEL, BYTE_ZERO);
      idle(1);
      urma_line_src_i.send(8'h0a, 5);
      idle(4);
      rd(OFS_HOLD, 8'h0a);
      // Interrupt identity is never read in bursts here
      idle(3);
      if (exp_q.size() != 0) begin
         fail("reads left unanswered");
      end
      test_done();
   end
endmodule : uart_register_map_access_tb

// ### verif/urma_line_src.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Far-end serial transmitter feeding the receive pin
// ---------------------------------------------------------------
module urma_line_src #(
   parameter int BIT_CLKS = 16
) (
   input wire logic sys_clk,
   output logic rx_line
);
   // Line rests at mark level between frames
   initial rx_line = 1'b1;

   // One frame: start bit, data LSB first, one stop bit
   task automatic send(input logic [7:0] data, input int nbits);
      @(negedge sys_clk);
      rx_line = 1'b0;
      repeat (BIT_CLKS) @(negedge sys_clk);
      for (int i = 0; i < nbits; i++) begin
         rx_line = data[i];
         repeat (BIT_CLKS) @(negedge sys_clk);
      end
      // Full stop bit so the next start edge is clean
      rx_line = 1'b1;
      repeat (BIT_CLKS) @(negedge sys_clk);
   endtask : send
endmodule : urma_line_src
